// File: logic/system_clock_select.sv
// Summary of operation
// - power-on source comes from config fields
// - instruction and peripheral clocks are source/2
// - prescaler code gives divide by code+2
// - feedback field sets the multiplier
// - multiplier is code+2, reset code gives 50
// - postscaler 2,4,8; code 10 reserved
// - output is input*M/(N1*N2)
// - eight-code source encoding, erased is 111
// - primary submode only for primary sources
// - switch request clears when switch done
// - control writes need unlock sequence
// - secondary enable bit turns oscillator on/off
// - interrupt with recover bit clears slowdown
// - fast RC postscaler divides by power two
`timescale 1ns/1ps
module system_clock_select
  import clock_select_pkg::*;
#(
  parameter int SWITCH_SETTLE = 10
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // configuration fields
  input  wire logic [2:0]  initial_source_select,
  input  wire logic [1:0]  primary_submode_select,
  // oscillator status and events
  input  wire logic        pll_lock_in,
  input  wire logic        clock_fail_in,
  input  wire logic        interrupt_in,
  // clock control outputs
  output source_t          active_source,
  output primary_mode_t    primary_mode,
  output logic             pll_in_use,
  output logic             secondary_osc_on,
  output clock_factors_t   factors,
  output logic             sys_clk_div2,
  output logic             proc_clk_en
);

  // two-flop synchronisers for pins from outside
  // lock, fail and interrupt come from other clock domains; straps from fuses
  // only the second stage of each pair is read by logic
  logic [1:0] lock_sync, fail_sync, irq_sync, cfg_sync;
  logic [2:0] src_cfg_s1, src_cfg_s2;
  logic [1:0] mode_cfg_s1, mode_cfg_s2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_sync   <= 2'h0;
      fail_sync   <= 2'h0;
      irq_sync    <= 2'h0;
      src_cfg_s1  <= 3'h7;
      src_cfg_s2  <= 3'h7;
      mode_cfg_s1 <= 2'h3;
      mode_cfg_s2 <= 2'h3;
    end else begin
      lock_sync   <= {lock_sync[0], pll_lock_in};
      fail_sync   <= {fail_sync[0], clock_fail_in};
      irq_sync    <= {irq_sync[0], interrupt_in};
      src_cfg_s1  <= initial_source_select;
      src_cfg_s2  <= src_cfg_s1;
      mode_cfg_s1 <= primary_submode_select;
      mode_cfg_s2 <= mode_cfg_s1;
    end
  end

  // strap capture: config is taken a few edges after release, then held
  // two edges fill the strap synchroniser before the capture edge
  // capturing once means a strap that moves later changes nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg_sync <= 2'h0;
    else if (cfg_sync != 2'h3) cfg_sync <= cfg_sync + 2'h1;
  end
  logic cfg_load;
  assign cfg_load = (cfg_sync == 2'h2);

  // apb decode, zero wait states
  // every register answers in its access cycle, so pready never drops
  // an unmapped access is flagged with pslverr; a write there only disarms the unlock
  logic wr_en, rd_en;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(paddr == OSC_CONTROL_OFFSET ||
                   paddr == CLOCK_DIVISOR_OFFSET || paddr == FEEDBACK_DIV_OFFSET ||
                   paddr == UNLOCK_OFFSET);

  // unlock sequence: key1 then key2 arms one control write
  // key2 must follow key1 with no other write between, reads do not disarm; the armed state lasts for one write
  // this guards the clock setup against a stray store from runaway code
  logic [1:0] unlock_reg;
  logic       ctrl_wr;
  assign ctrl_wr = wr_en && paddr == OSC_CONTROL_OFFSET && unlock_reg == 2'h2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) unlock_reg <= 2'h0;
    else if (wr_en) begin
      if (paddr == UNLOCK_OFFSET && pwdata[15:0] == UNLOCK_KEY1) unlock_reg <= 2'h1;
      else if (paddr == UNLOCK_OFFSET && pwdata[15:0] == UNLOCK_KEY2 && unlock_reg == 2'h1)
        unlock_reg <= 2'h2;
      else unlock_reg <= 2'h0; // any other write disarms, so one write per unlock
    end
  end

  // oscillator control state
  // the fail input is a level, so the flag is held set while it lasts
  source_t       cur_src_reg, new_src_reg;
  primary_mode_t pri_mode_reg;
  logic          set_lock_reg, sec_en_reg, switch_reg, fail_reg;
  logic [3:0]    settle_reg;
  logic          fail_evt;
  assign fail_evt = fail_sync[1];

  // source registers: config loads at power-on, switch moves new to current
  // the strap load wins over everything else in its one cycle
  // the setting lock freezes only the new source field, not the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_src_reg  <= SRC_FRC_DIV_N;
      new_src_reg  <= SRC_FRC_DIV_N;
      pri_mode_reg <= PRI_OFF;
    end else if (cfg_load) begin
      cur_src_reg  <= source_t'(src_cfg_s2);
      new_src_reg  <= source_t'(src_cfg_s2);
      pri_mode_reg <= primary_mode_t'(mode_cfg_s2);
    end else begin
      if (ctrl_wr && !set_lock_reg)
        new_src_reg <= source_t'(pwdata[NEW_SRC_LSB +: 3]);
      if (switch_reg && settle_reg == 4'(SWITCH_SETTLE))
        cur_src_reg <= new_src_reg;
    end
  end

  // switch request: cleared at once if redundant, else after lock and settle
  // a pll target waits for the synchronised lock before settling starts
  // settle counts pclk cycles, a stand-in for cycles of the new clock
  // a request that lands on the strap load cycle is dropped
  logic pll_target;
  assign pll_target = (new_src_reg == SRC_PRIMARY_PLL) || (new_src_reg == SRC_FAST_RC_PLL);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_reg <= 1'b0;
      settle_reg <= 4'h0;
    end else if (!switch_reg) begin
      settle_reg <= 4'h0;
      if (ctrl_wr && pwdata[SWITCH_BIT] && !cfg_load) switch_reg <= 1'b1;
    end else if (cur_src_reg == new_src_reg) begin
      switch_reg <= 1'b0;
    end else if (settle_reg == 4'(SWITCH_SETTLE)) begin
      switch_reg <= 1'b0;
    end else if (!pll_target || lock_sync[1]) begin
      settle_reg <= settle_reg + 4'h1;
    end
  end

  // clock setting lock and secondary enable
  // the secondary enable follows software even while a switch runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_lock_reg <= 1'b0;
      sec_en_reg   <= 1'b0;
    end else if (ctrl_wr) begin
      set_lock_reg <= pwdata[SET_LOCK_BIT];
      sec_en_reg   <= pwdata[SEC_EN_BIT];
    end
  end

  // fail flag: hardware sets, software clears by writing zero; set wins
  // a real switch starts with a clean flag, a redundant one leaves it
  // set wins so a failure seen during a clear is never lost
  logic switch_start;
  assign switch_start = switch_reg && settle_reg == 4'h0 && cur_src_reg != new_src_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fail_reg <= 1'b0;
    else if (fail_evt) fail_reg <= 1'b1;
    else if ((ctrl_wr && !pwdata[FAIL_BIT]) || switch_start) fail_reg <= 1'b0;
  end

  // clock divisor register
  // bit 5 is unimplemented and always reads zero
  // the interrupt is edge detected, so a held level clears the enable once
  logic [15:0] div_reg;
  logic [8:0]  fbd_reg;
  logic        irq_prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_prev <= 1'b0;
    else irq_prev <= irq_sync[1];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_reg <= CLOCK_DIVISOR_RESET;
    else begin
      if (wr_en && paddr == CLOCK_DIVISOR_OFFSET)
        div_reg <= {pwdata[15:6], 1'b0, pwdata[4:0]};
      // interrupt edge wins over a concurrent write of the enable
      if (div_reg[ROI_BIT] && irq_sync[1] && !irq_prev)
        div_reg[SLOW_EN_BIT] <= 1'b0;
    end
  end

  // feedback divisor register
  // bits above the nine-bit field are dropped; reset code 48 gives 50
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fbd_reg <= FEEDBACK_DIV_RESET;
    else if (wr_en && paddr == FEEDBACK_DIV_OFFSET) fbd_reg <= pwdata[8:0];
  end

  // factors for the analog macros; output = in*M/(N1*N2)
  // the macros see factors, not codes, so they need no decode of their own
  // the reserved postscaler code gives no divisor and drops post_valid
  logic [1:0] post_code;
  logic [2:0] slow_code;
  assign post_code = div_reg[POST_LSB +: 2];
  assign slow_code = div_reg[SLOW_EN_BIT] ? div_reg[SLOW_LSB +: 3] : 3'h0;
  always_comb begin
    factors.prescale   = {1'b0, div_reg[PRE_LSB +: 5]} + 6'h02;
    factors.multiplier = {1'b0, fbd_reg} + 10'h002;
    factors.post_valid = (post_code != POST_RESERVED);
    unique case (post_code)
      2'b00:   factors.postscale = 4'h2;
      2'b01:   factors.postscale = 4'h4;
      2'b11:   factors.postscale = 4'h8;
      default: factors.postscale = 4'h0; // reserved: no divisor
    endcase
    unique case (div_reg[FRC_POST_LSB +: 3])
      3'h0: factors.frc_divide = 9'h001;
      3'h1: factors.frc_divide = 9'h002;
      3'h2: factors.frc_divide = 9'h004;
      3'h3: factors.frc_divide = 9'h008;
      3'h4: factors.frc_divide = 9'h010;
      3'h5: factors.frc_divide = 9'h020;
      3'h6: factors.frc_divide = 9'h040;
      3'h7: factors.frc_divide = 9'h100; // top code jumps to 1:256
    endcase
    unique case (slow_code)
      3'h0:    factors.slow_divide = 4'h1;
      3'h1:    factors.slow_divide = 4'h2;
      3'h2:    factors.slow_divide = 4'h4;
      default: factors.slow_divide = 4'h8; // 1:8 and wider codes saturate
    endcase
  end

  // the submode only means something while a primary source runs
  assign active_source    = cur_src_reg;
  assign primary_mode     = (cur_src_reg == SRC_PRIMARY || cur_src_reg == SRC_PRIMARY_PLL) ?
                            pri_mode_reg : PRI_OFF;
  assign pll_in_use       = (cur_src_reg == SRC_PRIMARY_PLL) ||
                            (cur_src_reg == SRC_FAST_RC_PLL);
  assign secondary_osc_on = sec_en_reg;

  // reference divide by two for instruction/peripheral time base
  // a toggle stands in for the half-rate tick; no second clock is made
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sys_clk_div2 <= 1'b0;
    else sys_clk_div2 <= ~sys_clk_div2;
  end

  // processor slowdown: one enable per ratio peripheral ticks
  // the count moves only on half-rate ticks, so ratios are of the peripheral clock
  // a new ratio takes hold at the next half-rate tick, without waiting for a wrap
  logic [3:0] slow_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) slow_cnt <= 4'h0;
    else if (sys_clk_div2) slow_cnt <= (slow_cnt + 4'h1 >= factors.slow_divide) ? 4'h0 :
                                       slow_cnt + 4'h1;
  end
  assign proc_clk_en = sys_clk_div2 && slow_cnt == 4'h0;

  // register read mux, registered data
  // read data is captured in the setup cycle and stands through access
  // unimplemented bits and the write-only unlock register read as zero
  logic [15:0] osc_view;
  always_comb begin
    osc_view = 16'h0000;
    osc_view[CUR_SRC_LSB +: 3] = cur_src_reg;
    osc_view[NEW_SRC_LSB +: 3] = new_src_reg;
    osc_view[SET_LOCK_BIT]     = set_lock_reg;
    osc_view[PLL_LOCK_BIT]     = lock_sync[1];
    osc_view[FAIL_BIT]         = fail_reg;
    osc_view[SEC_EN_BIT]       = sec_en_reg;
    osc_view[SWITCH_BIT]       = switch_reg;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (rd_en && !penable) begin
      unique case (paddr)
        OSC_CONTROL_OFFSET:   prdata <= {16'h0000, osc_view};
        CLOCK_DIVISOR_OFFSET: prdata <= {16'h0000, div_reg};
        FEEDBACK_DIV_OFFSET:  prdata <= {23'h000000, fbd_reg};
        default:              prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// File: logic/clock_select_pkg.sv
package clock_select_pkg;

  // register byte offsets on the APB
  localparam logic [7:0] OSC_CONTROL_OFFSET  = 8'h00;
  localparam logic [7:0] CLOCK_DIVISOR_OFFSET = 8'h04;
  localparam logic [7:0] FEEDBACK_DIV_OFFSET  = 8'h08;
  localparam logic [7:0] UNLOCK_OFFSET        = 8'h0C;

  // unlock keys, written in this order to the unlock register
  localparam logic [15:0] UNLOCK_KEY1 = 16'h0057;
  localparam logic [15:0] UNLOCK_KEY2 = 16'h00AA;

  // oscillator control field positions
  localparam int CUR_SRC_LSB   = 12;
  localparam int NEW_SRC_LSB   = 8;
  localparam int SET_LOCK_BIT  = 7;
  localparam int PLL_LOCK_BIT  = 5;
  localparam int FAIL_BIT      = 3;
  localparam int SEC_EN_BIT    = 1;
  localparam int SWITCH_BIT    = 0;

  // clock divisor field positions
  localparam int ROI_BIT        = 15;
  localparam int SLOW_LSB       = 12;
  localparam int SLOW_EN_BIT    = 11;
  localparam int FRC_POST_LSB   = 8;
  localparam int POST_LSB       = 6;
  localparam int PRE_LSB        = 0;

  // reset values
  localparam logic [15:0] CLOCK_DIVISOR_RESET = 16'h3040;
  localparam logic [8:0]  FEEDBACK_DIV_RESET  = 9'h030;

  // postscaler reserved code
  localparam logic [1:0] POST_RESERVED = 2'b10;

  // source codes
  typedef enum logic [2:0] {
    SRC_FAST_RC     = 3'h0,
    SRC_FAST_RC_PLL = 3'h1,
    SRC_PRIMARY     = 3'h2,
    SRC_PRIMARY_PLL = 3'h3,
    SRC_SECONDARY   = 3'h4,
    SRC_LOW_POWER   = 3'h5,
    SRC_FRC_DIV16   = 3'h6,
    SRC_FRC_DIV_N   = 3'h7
  } source_t;

  // primary submodes
  typedef enum logic [1:0] {
    PRI_EXT_CLOCK = 2'h0,
    PRI_STD_XTAL  = 2'h1,
    PRI_HS_XTAL   = 2'h2,
    PRI_OFF       = 2'h3
  } primary_mode_t;

  // factors presented to the oscillator macros
  typedef struct packed {
    logic [5:0] prescale;
    logic [9:0] multiplier;
    logic [3:0] postscale;
    logic       post_valid;
    logic [8:0] frc_divide;
    logic [3:0] slow_divide;
  } clock_factors_t;

endpackage

// File: dv/clock_checker.sv
`timescale 1ns/1ps
module clock_checker
  import clock_select_pkg::*;
(
  // apb side
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [7:0]     paddr,
  input wire logic [31:0]    pwdata,
  // clock side
  input wire source_t        active_source,
  input wire primary_mode_t  primary_mode,
  input wire logic           pll_in_use,
  input wire clock_factors_t factors,
  input wire logic           sys_clk_div2,
  input wire logic           proc_clk_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wd;
  logic wf;
  // completed writes; factors follow the registers at once, one edge after the write
  assign wd = psel && penable && pwrite && paddr == CLOCK_DIVISOR_OFFSET;
  assign wf = psel && penable && pwrite && paddr == FEEDBACK_DIV_OFFSET;
  pre_map_a: assert property (wd |=> factors.prescale == {1'b0, $past(pwdata[4:0])} + 6'h02)
    else $error("prescale wrong");
  mult_map_a: assert property (wf |=> factors.multiplier == {1'b0, $past(pwdata[8:0])} + 10'h002)
    else $error("multiplier wrong");
  post_map_a: assert property (wd |=> factors.post_valid == ($past(pwdata[7:6]) != POST_RESERVED)
    && factors.postscale == ($past(pwdata[7]) ? ($past(pwdata[6]) ? 4'h8 : 4'h0)
    : ($past(pwdata[6]) ? 4'h4 : 4'h2))) else $error("postscale wrong");
  frc_map_a: assert property (wd |=> factors.frc_divide ==
    (($past(pwdata[10:8]) == 3'h7) ? 9'h100 : 9'h001 << $past(pwdata[10:8])))
    else $error("fast rc divide wrong");
  slow_map_a: assert property (wd |=> factors.slow_divide == (!$past(pwdata[11]) ? 4'h1
    : $past(pwdata[14]) ? 4'h8 : 4'h1 << $past(pwdata[13:12]))) else $error("slowdown wrong");
  half_rate_a: assert property (sys_clk_div2 |=> !sys_clk_div2 ##1 sys_clk_div2)
    else $error("half rate clock not toggling");
  proc_en_a: assert property (proc_clk_en |-> sys_clk_div2)
    else $error("processor enable off the half rate phase");
  pll_use_a: assert property (pll_in_use == (active_source inside {SRC_FAST_RC_PLL, SRC_PRIMARY_PLL}))
    else $error("pll use mismatch");
  sub_mode_a: assert property (!(active_source inside {SRC_PRIMARY, SRC_PRIMARY_PLL})
    |-> primary_mode == PRI_OFF) else $error("submode shown for non primary");
endmodule
bind system_clock_select clock_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .active_source, .primary_mode, .pll_in_use, .factors, .sys_clk_div2,
  .proc_clk_en);

// File: dv/osc_model.sv
`timescale 1ns/1ps
module osc_model (
  // commands
  input wire logic pclk,
  input wire logic pll_on,
  input wire logic fail_cmd,
  // status
  output logic     pll_lock_in,
  output logic     clock_fail_in
);
  logic [2:0] cnt;
  // lock is slow on purpose, so a pll switch must really wait for it
  always_ff @(posedge pclk) begin
    if (!pll_on)
      cnt <= 3'h0;
    else if (cnt != 3'h7)
      cnt <= cnt + 3'h1;
  end
  assign pll_lock_in = cnt == 3'h7;
  // a failing oscillator shows as a level
  assign clock_fail_in = fail_cmd;
endmodule

// File: dv/system_clock_select_pll_doze_test.sv
`timescale 1ns/1ps
module system_clock_select_pll_doze_test
  import clock_select_pkg::*;
;
  typedef struct packed {logic [15:0] div; logic [8:0] fbd; clock_factors_t f;} row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic pll_lock_in, clock_fail_in, interrupt_in, pll_on, fail_cmd;
  logic pll_in_use, secondary_osc_on, sys_clk_div2, proc_clk_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  source_t active_source;
  source_t strap_src;
  primary_mode_t strap_mode;
  primary_mode_t primary_mode;
  clock_factors_t factors;
  int n_fail = 0;
  int checks = 0;
  // divisor and feedback codes beside the factors they give
  row_t rows [5] = '{
    '{16'h0000, 9'h000, '{6'h02, 10'h002, 4'h2, 1'b1, 9'h001, 4'h1}},
    '{16'h0F5F, 9'h1FF, '{6'h21, 10'h201, 4'h4, 1'b1, 9'h100, 4'h1}},
    '{16'h3AC1, 9'h01E, '{6'h03, 10'h020, 4'h8, 1'b1, 9'h004, 4'h8}},
    '{16'h5980, 9'h030, '{6'h02, 10'h032, 4'h0, 1'b0, 9'h002, 4'h8}},
    '{16'h2440, 9'h001, '{6'h02, 10'h003, 4'h4, 1'b1, 9'h010, 4'h1}}};
  logic [15:0] fail_wr [3] = '{16'h0108, 16'h0100, 16'h0108};
  logic fail_exp [3] = '{1'b1, 1'b0, 1'b0};

  system_clock_select #(.SWITCH_SETTLE(2)) u_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .initial_source_select(strap_src), .primary_submode_select(strap_mode),
    .pll_lock_in, .clock_fail_in, .interrupt_in, .active_source, .primary_mode,
    .pll_in_use, .secondary_osc_on, .factors, .sys_clk_div2, .proc_clk_en);
  osc_model u_osc (.pclk, .pll_on, .fail_cmd, .pll_lock_in, .clock_fail_in);

  // 40 MHz
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one apb transfer, then an idle cycle so no signal is set twice at one edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // control writes go behind the two unlock keys
  task automatic ctl(input logic [15:0] d);
    apb(1'b1, UNLOCK_OFFSET, {16'h0, UNLOCK_KEY1});
    apb(1'b1, UNLOCK_OFFSET, {16'h0, UNLOCK_KEY2});
    apb(1'b1, OSC_CONTROL_OFFSET, {16'h0, d});
  endtask

  // request a switch and poll until the request bit drops
  task automatic switch_to(input logic [15:0] d);
    int n;
    n = 0;
    ctl(d);
    do begin
      apb(1'b0, OSC_CONTROL_OFFSET, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 40);
    chk(64'(q[0]), 64'h0);
    if (q[0] !== 1'b0)
      wrap_up();
  endtask

  initial begin
    int n;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    interrupt_in = 1'b0;
    pll_on = 1'b0;
    fail_cmd = 1'b0;
    strap_src = SRC_PRIMARY;
    strap_mode = PRI_HS_XTAL;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, CLOCK_DIVISOR_OFFSET, 32'h0);
    chk(64'(q), 64'h3040);
    apb(1'b0, FEEDBACK_DIV_OFFSET, 32'h0);
    chk(64'({q, factors.multiplier}), 64'({32'h30, 10'h032}));
    apb(1'b0, OSC_CONTROL_OFFSET, 32'h0);
    chk(64'({q, active_source, primary_mode}), 64'({32'h2200, SRC_PRIMARY, PRI_HS_XTAL}));
    // a control write without the keys must be dropped
    apb(1'b1, OSC_CONTROL_OFFSET, 32'h0003);
    apb(1'b0, OSC_CONTROL_OFFSET, 32'h0);
    chk(64'(q), 64'h2200);
    // primary to fast rc, then on to fast rc with pll
    switch_to(16'h0003);
    chk(64'({active_source, secondary_osc_on}), 64'({SRC_FAST_RC, 1'b1}));
    pll_on <= 1'b1;
    switch_to(16'h0101);
    chk(64'({q, pll_in_use, secondary_osc_on}), 64'({32'h1120, 2'b10}));
    // fail flag is sticky and software can only clear it
    fail_cmd <= 1'b1;
    repeat (4) @(posedge pclk);
    fail_cmd <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      ctl(fail_wr[i]);
      apb(1'b0, OSC_CONTROL_OFFSET, 32'h0);
      chk(64'(q[3]), 64'(fail_exp[i]));
    end
    foreach (rows[i]) begin
      apb(1'b1, CLOCK_DIVISOR_OFFSET, {16'h0, rows[i].div});
      apb(1'b1, FEEDBACK_DIV_OFFSET, {23'h0, rows[i].fbd});
      chk(64'(factors), 64'(rows[i].f));
      apb(1'b0, CLOCK_DIVISOR_OFFSET, 32'h0);
      chk(64'(q), 64'(rows[i].div));
    end
    // interrupt with recover set drops the slowdown
    apb(1'b1, CLOCK_DIVISOR_OFFSET, 32'hB800);
    chk(64'(factors.slow_divide), 64'h8);
    // at 1:8 the processor enable comes once in every sixteen pclk cycles
    n = 0;
    repeat (32) begin
      @(negedge pclk);
      if (proc_clk_en === 1'b1) n++;
    end
    @(posedge pclk);
    chk(64'(n), 64'h2);
    interrupt_in <= 1'b1;
    n = 0;
    while (factors.slow_divide !== 4'h1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    if (n == 10) begin
      n_fail++;
      wrap_up();
    end
    apb(1'b0, CLOCK_DIVISOR_OFFSET, 32'h0);
    chk(64'({q, factors.slow_divide}), 64'({32'hB000, 4'h1}));
    // unmapped address answers with an error and zero
    apb(1'b0, 8'h10, 32'h0);
    chk(64'({e, q}), 64'h1_0000_0000);
    // a second power-on reset restores the registers and takes the erased strap
    strap_src <= SRC_FRC_DIV_N;
    pll_on <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, CLOCK_DIVISOR_OFFSET, 32'h0);
    chk(64'(q), 64'h3040);
    apb(1'b0, OSC_CONTROL_OFFSET, 32'h0);
    chk(64'({q, active_source, primary_mode}), 64'({32'h7700, SRC_FRC_DIV_N, PRI_OFF}));
    wrap_up();
  end
endmodule
